// *** src/capture_filter.sv ***
// Capture pin synchroniser, noise canceler and edge detector
`timescale 1ns/1ps
`include "timer16_defines.svh"

module capture_filter (
   input wire logic hclk, // Clock
   input wire logic hresetn, // Async reset, low
   input wire logic pin, // Raw capture pin
   input wire logic filter_on, // Noise canceler enable
   input wire logic rising, // 1 rising, 0 falling
   output logic trigger // One-cycle capture trigger
);
   logic sync1;
   logic sync2;
   logic [2:0] run;
   logic filt;
   logic last;
   logic chosen;
   wire differs = sync2 != filt;
   wire settled = differs && (run == `FILTER_SAMPLES - 3'h1);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         run <= 3'h0;
         filt <= 1'b0;
         last <= 1'b0;
      end else begin
         sync1 <= pin;
         sync2 <= sync1;
         run <= differs && !settled ? run + 3'h1 : 3'h0;
         // Output moves after four equal samples
         if (settled)
            filt <= sync2; // see RL1
         else if (!filter_on)
            filt <= sync2;
         last <= chosen;
      end
   end

   // Filtered path lags by four samples
   assign chosen = filter_on ? filt : sync2; // see RL2
   assign trigger = rising ? (chosen && !last) : (!chosen && last); // see RL3

   a_filter_hold: assert property (@(posedge hclk) disable iff (!hresetn)
      filter_on && $past(filter_on) && !$past(settled)
      |-> filt == $past(filt)) // see RL1
      else $error("filtered input moved without four samples");

endmodule : capture_filter

// *** src/count_clock_select.sv ***
// Prescaler and count clock enable generator
`timescale 1ns/1ps
`include "timer16_defines.svh"

module count_clock_select (
   input wire logic hclk, // Clock
   input wire logic hresetn, // Async reset, low
   input wire logic [2:0] sel, // Clock select field
   input wire logic ext_pin, // External count pin
   output logic tick // One-cycle count enable
);
   logic [9:0] pre;
   logic e1;
   logic e2;
   logic e3;
   wire ext_rise = e2 && !e3;
   wire ext_fall = !e2 && e3;
   logic next_tick;

   always_comb begin
      unique case (timer16_pkg::clock_select_e'(sel)) // see RL7
         timer16_pkg::CS_STOP: next_tick = 1'b0;
         timer16_pkg::CS_DIV1: next_tick = 1'b1;
         timer16_pkg::CS_DIV8: next_tick = pre[2:0] == 3'h7;
         timer16_pkg::CS_DIV64: next_tick = pre[5:0] == 6'h3f;
         timer16_pkg::CS_DIV256: next_tick = pre[7:0] == 8'hff;
         timer16_pkg::CS_DIV1024: next_tick = pre == 10'h3ff;
         // Pin sampled whatever its direction
         timer16_pkg::CS_EXT_FALL: next_tick = ext_fall; // see RL8 RL9
         timer16_pkg::CS_EXT_RISE: next_tick = ext_rise; // see RL8 RL9
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pre <= 10'h000;
         e1 <= 1'b0;
         e2 <= 1'b0;
         e3 <= 1'b0;
      end else begin
         pre <= pre + 10'h001;
         e1 <= ext_pin;
         e2 <= e1;
         e3 <= e2;
      end
   end

   assign tick = next_tick;

   a_stop_no_tick: assert property (@(posedge hclk) disable iff (!hresetn)
      sel == 3'h0 |-> !tick) // see RL7
      else $error("tick while stopped");
   a_div8_spacing: assert property (@(posedge hclk) disable iff (!hresetn)
      sel == 3'h2 && tick ##1 sel == 3'h2 [*7] |-> !$past(tick)) // see RL7
      else $error("divide by 8 ticks too close");

endmodule : count_clock_select

// *** src/timer16_capture_compare_regs.sv ***
// 16-bit timer with capture, two compares and AHB-Lite registers
//
// The implementer's own choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "timer16_defines.svh"

// Summary of operation
// RL1: With filter on, capture input changes only after four equal samples.
// RL2: Filtered captures arrive four clock cycles later than unfiltered.
// RL3: Edge select bit zero means falling edge, one means rising.
// RL4: Capture trigger copies counter into capture register, sets capture flag.
// RL5: When capture register is TOP, the capture pin is ignored.
// RL6: Software writes zero to control bit 5; it reads zero.
// RL7: Clock select 000 stops; 001..101 divide by 1,8,64,256,1024.
// RL8: Codes 110 and 111 count falling or rising external pin edges.
// RL9: External pin counts even when driven as an output.
// RL10: All 16-bit registers share one high-byte latch.
// RL11: Counter write blocks compare match on the next timer tick.
// RL12: Both compare registers are compared with the counter always.
// RL13: Capture source is the pin or the analog comparator.
// RL14: Enabled flag with global enable raises its interrupt request.
// RL15: With capture register as TOP, capture flag sets at TOP.
// RL16: Compare flag sets on the tick after counter equals compare.
// RL17: A forced compare never sets the compare flag.
// RL18: Flags clear on vector acknowledge or writing one.
// RL19: Overflow flag sets per mode; MAX in normal and clear modes.
// RL20: Four-bit mode sets TOP, buffer update and overflow point.
// RL21: High byte written first to latch; low write commits; low read latches.
module timer16_capture_compare_regs (
   input wire logic hclk, // Bus and timer clock
   input wire logic hresetn, // Async reset, low
   input wire logic hsel, // Slave select
   input wire logic [31:0] haddr, // Address
   input wire logic [1:0] htrans, // Transfer type
   input wire logic hwrite, // Write
   input wire logic [2:0] hsize, // Size
   input wire logic [31:0] hwdata, // Write data
   input wire logic hready, // Bus ready
   output logic [31:0] hrdata, // Read data
   output logic hreadyout, // Slave ready
   output logic hresp, // Response
   input wire logic capture_input_pin, // Capture pin
   input wire logic analog_compare, // Analog comparator output
   input wire logic external_count_pin, // External count pin
   input wire logic [3:0] vector_ack, // Vector taken: capt,cmpa,cmpb,ovf
   output logic [3:0] irq_request, // Requests: capt,cmpa,cmpb,ovf
   output logic [1:0] compare_output_pin // Compare match strobes B,A
);
   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   timer16_pkg::bus_state_e bus_state;
   logic [11:0] addr_q;
   logic write_q;
   logic [7:0] control_a;
   logic [7:0] control_b;
   logic [7:0] control_x;
   logic [7:0] irq_mask_reg;
   logic [7:0] irq_flag_reg;
   logic [7:0] high_latch;
   logic [15:0] counter_value;
   logic [15:0] compare_a_value;
   logic [15:0] compare_b_value;
   logic [15:0] compare_a_buf;
   logic [15:0] compare_b_buf;
   logic [15:0] capture_register;
   logic count_down;
   logic block_match;
   logic [1:0] match_q;

   // ------------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------------
   wire take = hsel && hready && htrans[1];
   wire in_data = bus_state == timer16_pkg::BUS_DATA;
   wire wr = in_data && write_q;
   wire rd_lo = in_data && !write_q;
   wire [7:0] wb = hwdata[7:0];
   wire wr_ctla = wr && addr_q == `OFF_CONTROL_A;
   wire wr_ctlb = wr && addr_q == `OFF_CONTROL_B;
   wire wr_ctlx = wr && addr_q == `OFF_CONTROL_X;
   wire wr_mask = wr && addr_q == `OFF_IRQ_MASK;
   wire wr_flag = wr && addr_q == `OFF_IRQ_FLAG;
   wire wr_cnt_lo = wr && addr_q == `OFF_COUNT_LO;
   wire wr_cmpa_lo = wr && addr_q == `OFF_CMP_A_LO;
   wire wr_cmpb_lo = wr && addr_q == `OFF_CMP_B_LO;
   wire wr_capt_lo = wr && addr_q == `OFF_CAPT_LO;
   wire wr_high = wr && (addr_q == `OFF_COUNT_HI ||
      addr_q == `OFF_CMP_A_HI || addr_q == `OFF_CMP_B_HI ||
      addr_q == `OFF_CAPT_HI);
   wire [15:0] wide_wr = {high_latch, wb};

   // ------------------------------------------------------------------
   // Mode decode
   // ------------------------------------------------------------------
   wire [3:0] waveform_mode_field = {control_b[4:3], control_a[1:0]};
   wire [1:0] waveform_mode_upper = control_b[4:3];
   wire mode_normal = waveform_mode_field == 4'h0;
   wire mode_ctc_a = waveform_mode_field == 4'h4;
   wire mode_ctc_i = waveform_mode_field == 4'hc;
   wire mode_fast = waveform_mode_field inside {4'h5, 4'h6, 4'h7, 4'he,
      4'hf};
   wire mode_dual = waveform_mode_field inside {4'h1, 4'h2, 4'h3, 4'h8,
      4'h9, 4'ha, 4'hb};
   wire update_at_top = waveform_mode_field inside {4'h1, 4'h2, 4'h3,
      4'ha, 4'hb};
   wire nonpwm = mode_normal || mode_ctc_a || mode_ctc_i;
   wire top_is_capt = waveform_mode_field inside {4'h8, 4'ha, 4'hc, 4'he};
   wire top_is_cmpa = waveform_mode_field inside {4'h4, 4'h9, 4'hb, 4'hf};
   wire [1:0] fixed_width = waveform_mode_field[1:0];
   wire [15:0] fixed_top = fixed_width == 2'h1 ? `TOP_8BIT :
      fixed_width == 2'h2 ? `TOP_9BIT : `TOP_10BIT;
   wire [15:0] top_value = top_is_capt ? capture_register : // see RL20
      top_is_cmpa ? compare_a_value : mode_normal ? `TOP_MAX : fixed_top;
   wire at_top = counter_value == top_value;
   wire at_bottom = counter_value == 16'h0000;
   wire at_max = counter_value == `TOP_MAX;

   // ------------------------------------------------------------------
   // Count clock and capture source
   // ------------------------------------------------------------------
   logic tick;
   logic pin_trigger;
   logic an1;
   logic an2;
   wire capture_source = control_x[`CX_ANALOG] ? an2 : // see RL13
      capture_input_pin;

   count_clock_select u_clk (
      .hclk(hclk),
      .hresetn(hresetn),
      .sel(control_b[2:0]),
      .ext_pin(external_count_pin),
      .tick(tick)
   );

   capture_filter u_capt (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin(capture_source),
      .filter_on(control_b[`CB_FILTER]),
      .rising(control_b[`CB_EDGE]),
      .trigger(pin_trigger)
   );

   wire capture_now = pin_trigger && !top_is_capt; // see RL5
   wire top_flag_capt = tick && top_is_capt && at_top; // see RL15

   // ------------------------------------------------------------------
   // Counter sequence
   // ------------------------------------------------------------------
   wire turn = tick && at_top;
   logic [15:0] next_count;
   logic next_down;
   always_comb begin
      next_count = counter_value;
      next_down = count_down;
      if (tick) begin
         if (mode_dual) begin
            if (!count_down && at_top) begin
               next_down = 1'b1;
               next_count = counter_value - 16'h0001;
            end else if (count_down && at_bottom) begin
               next_down = 1'b0;
               next_count = counter_value + 16'h0001;
            end else begin
               next_count = count_down ? counter_value - 16'h0001 :
                  counter_value + 16'h0001;
            end
         end else begin
            next_down = 1'b0;
            next_count = at_top ? 16'h0000 : counter_value + 16'h0001;
         end
      end
   end

   // ------------------------------------------------------------------
   // Compare and overflow events
   // ------------------------------------------------------------------
   wire [1:0] equal = {counter_value == compare_b_value,
      counter_value == compare_a_value}; // see RL12
   wire [1:0] set_cmp = tick && !block_match ? match_q : 2'b00; // see RL16
   wire ovf_event = tick && (nonpwm ? at_max :
      mode_fast ? at_top : (count_down && at_bottom)); // see RL19 RL20
   wire buf_load = nonpwm ? 1'b0 : update_at_top ? turn :
      (tick && at_bottom && !mode_fast) || (mode_fast && turn);
   wire [1:0] force_strobe = wr_ctla && nonpwm ?
      {wb[`CA_FORCE_B], wb[`CA_FORCE_A]} : 2'b00;

   wire [7:0] flag_set = {2'b00, capture_now || top_flag_capt,
      set_cmp[0], set_cmp[1], ovf_event, 2'b00}; // see RL4 RL17
   wire [7:0] flag_clr = (wr_flag ? wb : 8'h00) |
      {2'b00, vector_ack, 2'b00};
   wire [7:0] next_flags = (irq_flag_reg & ~flag_clr | flag_set)
      & `TIMER1_IRQ_BITS; // see RL18
   wire [7:0] pending = next_flags & irq_mask_reg;

   // ------------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------------
   logic [7:0] rd_byte;
   logic [7:0] rd_high;
   always_comb begin
      rd_high = 8'h00;
      unique case (addr_q)
         `OFF_CONTROL_A: rd_byte = control_a & 8'hf3;
         `OFF_CONTROL_B: rd_byte = control_b & 8'hdf; // see RL6
         `OFF_CONTROL_X: rd_byte = control_x;
         `OFF_IRQ_MASK: rd_byte = irq_mask_reg;
         `OFF_IRQ_FLAG: rd_byte = irq_flag_reg;
         `OFF_COUNT_LO: {rd_high, rd_byte} = counter_value;
         `OFF_CMP_A_LO: {rd_high, rd_byte} = compare_a_buf;
         `OFF_CMP_B_LO: {rd_high, rd_byte} = compare_b_buf;
         `OFF_CAPT_LO: {rd_high, rd_byte} = capture_register;
         `OFF_COUNT_HI, `OFF_CMP_A_HI, `OFF_CMP_B_HI,
         `OFF_CAPT_HI: rd_byte = high_latch;
         default: rd_byte = 8'h00;
      endcase
   end
   wire lo_read = rd_lo && addr_q inside {`OFF_COUNT_LO, `OFF_CMP_A_LO,
      `OFF_CMP_B_LO, `OFF_CAPT_LO};

   // ------------------------------------------------------------------
   // Bus slave
   // ------------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bus_state <= timer16_pkg::BUS_IDLE;
         addr_q <= 12'h000;
         write_q <= 1'b0;
         hrdata <= 32'h00000000;
      end else begin
         bus_state <= take ? timer16_pkg::BUS_DATA : timer16_pkg::BUS_IDLE;
         addr_q <= take ? {haddr[11:2], 2'b00} : addr_q;
         write_q <= take && hwrite;
         hrdata <= take && !hwrite ? 32'h00000000 : hrdata;
         if (rd_lo)
            hrdata <= {24'h000000, rd_byte};
      end
   end
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // ------------------------------------------------------------------
   // Control registers and high-byte latch
   // ------------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         control_a <= `CONTROL_RESET;
         control_b <= `CONTROL_RESET;
         control_x <= `CONTROL_RESET;
         irq_mask_reg <= `MASK_RESET;
         irq_flag_reg <= `FLAG_RESET;
         high_latch <= 8'h00;
         an1 <= 1'b0;
         an2 <= 1'b0;
      end else begin
         an1 <= analog_compare;
         an2 <= an1;
         if (wr_ctla)
            control_a <= wb & 8'hf3;
         if (wr_ctlb)
            control_b <= wb & 8'hdf; // see RL6
         if (wr_ctlx)
            control_x <= wb & 8'h03;
         if (wr_mask)
            irq_mask_reg <= wb;
         irq_flag_reg <= next_flags;
         if (wr_high)
            high_latch <= wb; // see RL21
         else if (lo_read)
            high_latch <= rd_high; // see RL10 RL21
      end
   end

   // ------------------------------------------------------------------
   // Timer datapath
   // ------------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         counter_value <= 16'h0000;
         count_down <= 1'b0;
         compare_a_value <= 16'h0000;
         compare_b_value <= 16'h0000;
         compare_a_buf <= 16'h0000;
         compare_b_buf <= 16'h0000;
         capture_register <= 16'h0000;
         block_match <= 1'b0;
         match_q <= 2'b00;
         irq_request <= 4'h0;
         compare_output_pin <= 2'b00;
      end else begin
         counter_value <= wr_cnt_lo ? wide_wr : next_count; // see RL10
         count_down <= next_down;
         if (wr_cnt_lo)
            block_match <= 1'b1; // see RL11
         else if (tick)
            block_match <= 1'b0;
         if (tick)
            match_q <= wr_cnt_lo ? 2'b00 : equal;
         if (wr_cmpa_lo)
            compare_a_buf <= wide_wr;
         if (wr_cmpb_lo)
            compare_b_buf <= wide_wr;
         if (nonpwm && wr_cmpa_lo)
            compare_a_value <= wide_wr;
         else if (buf_load)
            compare_a_value <= compare_a_buf;
         if (nonpwm && wr_cmpb_lo)
            compare_b_value <= wide_wr;
         else if (buf_load)
            compare_b_value <= compare_b_buf;
         if (wr_capt_lo && top_is_capt)
            capture_register <= wide_wr;
         else if (capture_now)
            capture_register <= counter_value; // see RL4
         irq_request <= control_x[`CX_GLOBAL] ? {pending[`IRQ_CAPT],
            pending[`IRQ_CMPA], pending[`IRQ_CMPB], pending[`IRQ_OVF]}
            : 4'h0; // see RL14
         compare_output_pin <= {set_cmp[1] | force_strobe[1],
            set_cmp[0] | force_strobe[0]}; // see RL12
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   a_capture_copy: assert property (@(posedge hclk) disable iff (!hresetn)
      capture_now && !wr_capt_lo |=> capture_register == $past(counter_value)
      && irq_flag_reg[`IRQ_CAPT]) // see RL4
      else $error("capture did not copy counter");
   a_capt_top_off: assert property (@(posedge hclk) disable iff (!hresetn)
      top_is_capt && !wr_capt_lo |=> $stable(capture_register)) // see RL5
      else $error("capture register moved while TOP");
   a_write_blocks: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_cnt_lo |=> !set_cmp[0] && !set_cmp[1]) // see RL11
      else $error("match after counter write");
   a_force_no_flag: assert property (@(posedge hclk) disable iff (!hresetn)
      force_strobe[0] && !set_cmp[0] && !irq_flag_reg[`IRQ_CMPA]
      |=> !irq_flag_reg[`IRQ_CMPA]) // see RL17
      else $error("forced compare set flag");
   a_flag_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_flag && wb[`IRQ_OVF] && !ovf_event |=> !irq_flag_reg[`IRQ_OVF])
      // see RL18
      else $error("overflow flag not cleared");
   a_normal_ovf: assert property (@(posedge hclk) disable iff (!hresetn)
      mode_normal && tick && at_max && !wr_flag && !vector_ack[0]
      |=> irq_flag_reg[`IRQ_OVF] && counter_value == 16'h0000) // see RL19
      else $error("normal mode overflow missed");
   a_irq_gate: assert property (@(posedge hclk) disable iff (!hresetn)
      !control_x[`CX_GLOBAL] |=> irq_request == 4'h0) // see RL14
      else $error("request without global enable");
   a_ctlb_rsvd: assert property (@(posedge hclk) disable iff (!hresetn)
      !control_b[`CB_RSVD]) // see RL6
      else $error("reserved bit stored");

   c_capture: cover property (@(posedge hclk) disable iff (!hresetn)
      capture_now);
   c_cmp_a: cover property (@(posedge hclk) disable iff (!hresetn)
      set_cmp[0]);
   c_ovf: cover property (@(posedge hclk) disable iff (!hresetn)
      ovf_event ##1 irq_request[0]);

endmodule : timer16_capture_compare_regs

// *** src/timer16_defines.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef TIMER16_DEFINES_SVH
`define TIMER16_DEFINES_SVH

// ---------------------------------------------------------------------
// Register byte addresses (one aligned word each)
// ---------------------------------------------------------------------
`define OFF_CONTROL_A 12'h000
`define OFF_CONTROL_B 12'h004
`define OFF_COUNT_LO 12'h008
`define OFF_COUNT_HI 12'h00c
`define OFF_CMP_A_LO 12'h010
`define OFF_CMP_A_HI 12'h014
`define OFF_CMP_B_LO 12'h018
`define OFF_CMP_B_HI 12'h01c
`define OFF_CAPT_LO 12'h020
`define OFF_CAPT_HI 12'h024
`define OFF_IRQ_MASK 12'h028
`define OFF_IRQ_FLAG 12'h02c
`define OFF_IRQ_ACK 12'h030
`define OFF_CONTROL_X 12'h034

// ---------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------
`define CB_FILTER 7
`define CB_EDGE 6
`define CB_RSVD 5
`define CA_FORCE_A 3
`define CA_FORCE_B 2
`define IRQ_CAPT 5
`define IRQ_CMPA 4
`define IRQ_CMPB 3
`define IRQ_OVF 2
`define TIMER1_IRQ_BITS 8'h3c
`define CX_GLOBAL 0
`define CX_ANALOG 1

// ---------------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------------
`define CONTROL_RESET 8'h00
`define MASK_RESET 8'h00
`define FLAG_RESET 8'h00
`define FILTER_SAMPLES 3'h4
`define TOP_8BIT 16'h00ff
`define TOP_9BIT 16'h01ff
`define TOP_10BIT 16'h03ff
`define TOP_MAX 16'hffff

`endif

// *** src/timer16_pkg.sv ***
// Types shared by the timer files
package timer16_pkg;

   // ------------------------------------------------------------------
   // Clock select codes
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      CS_STOP = 3'h0, CS_DIV1 = 3'h1, CS_DIV8 = 3'h2, CS_DIV64 = 3'h3,
      CS_DIV256 = 3'h4, CS_DIV1024 = 3'h5, CS_EXT_FALL = 3'h6,
      CS_EXT_RISE = 3'h7
   } clock_select_e;

   // ------------------------------------------------------------------
   // Bus slave states, one-hot
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_DATA = 2'b10
   } bus_state_e;

endpackage : timer16_pkg

// *** verif/tb_timer16_capture_compare_regs.sv ***
// Self-checking bench for the 16-bit timer register block
`timescale 1ns/1ps
module tb_timer16_capture_compare_regs;
   typedef struct {string n; logic [31:0] e; bit [1:0] s;} note_s;
   note_s notes[$];
   event take;
   logic hclk = 0, hresetn = 0, hwrite = 0, cpin = 0, xpin = 0;
   logic [1:0] htrans = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, g;
   logic [3:0] ack = 0, irq;
   logic [1:0] opin;
   logic hreadyout, hresp;
   logic [15:0] rv;
   int mismatches = 0, samples_checked = 0;
   always #2 hclk = ~hclk;
   timer16_capture_compare_regs u_timer16_capture_compare_regs (
      .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .capture_input_pin(cpin), .analog_compare(1'b0),
      .external_count_pin(xpin), .vector_ack(ack), .irq_request(irq),
      .compare_output_pin(opin));
   // ---------------------------------------------------------------
   // Bus tasks and checking
   // ---------------------------------------------------------------
   task summarize;
      $display("Checked %0d, mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : summarize
   task rdy;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 40);
      if (n >= 40) begin
         mismatches++;
         summarize();
      end
   endtask : rdy
   task wr(input logic [11:0] a, input logic [7:0] d);
      haddr <= {20'h0, a};
      hwrite <= 1'b1;
      htrans <= 2'b10;
      rdy();
      htrans <= 2'b00;
      hwdata <= {24'h0, d};
      rdy();
   endtask : wr
   task w16(input logic [11:0] a, input logic [15:0] v);
      wr(a + 12'h004, v[15:8]);
      wr(a, v[7:0]);
   endtask : w16
   task rd(input string n, input logic [11:0] a, input logic [7:0] e);
      haddr <= {20'h0, a};
      hwrite <= 1'b0;
      htrans <= 2'b10;
      rdy();
      htrans <= 2'b00;
      rdy();
      @(posedge hclk);
      notes.push_back('{n, {24'h0, e}, 2'd0});
      -> take;
   endtask : rd
   task obs(input logic [3:0] e);
      notes.push_back('{"irq_request", {28'h0, e}, 2'd1});
      -> take;
   endtask : obs
   task pin(input logic v, input int n);
      cpin <= v;
      repeat (n) @(posedge hclk);
   endtask : pin
   always @(take) begin
      note_s t;
      while (notes.size() > 0) begin
         t = notes.pop_front();
         g = t.s == 2'd1 ? {28'h0, irq} :
            t.s == 2'd2 ? {30'h0, opin} : hrdata;
         samples_checked++;
         if (g !== t.e) begin
            $display("Error %s expected %h seen %h", t.n, t.e, g);
            mismatches++;
         end
      end
   end
   initial begin
      repeat (100000) @(posedge hclk);
      mismatches++;
      summarize();
   end
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial begin
      void'($urandom(32'h4904f1ab));
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd("control_b", 12'h004, 8'h00);
      rd("irq_mask_reg", 12'h028, 8'h00);
      rd("irq_flag_reg", 12'h02c, 8'h00);
      rd("unmapped", 12'h030, 8'h00);
      wr(12'h004, 8'hf8);
      rd("control_b", 12'h004, 8'hd8);
      wr(12'h004, 8'h00);
      rv = 16'($urandom);
      w16(12'h010, rv);
      rd("cmp_a_lo", 12'h010, rv[7:0]);
      rd("cmp_a_hi", 12'h014, rv[15:8]);
      w16(12'h010, 16'h0010);
      w16(12'h018, 16'h8000);
      w16(12'h008, 16'h0000);
      wr(12'h004, 8'h01);
      repeat (100) @(posedge hclk);
      wr(12'h004, 8'h00);
      rd("irq_flag_reg", 12'h02c, 8'h10);
      wr(12'h028, 8'h10);
      wr(12'h034, 8'h01);
      repeat (2) @(posedge hclk);
      obs(4'b0100);
      ack <= 4'b0100;
      @(posedge hclk);
      ack <= 4'b0000;
      rd("irq_flag_reg", 12'h02c, 8'h00);
      obs(4'b0000);
      wr(12'h000, 8'h08);
      @(negedge hclk);
      notes.push_back('{"compare_output_pin", 32'h1, 2'd2});
      -> take;
      @(posedge hclk);
      rd("irq_flag_reg", 12'h02c, 8'h00);
      rv = 16'($urandom);
      w16(12'h008, rv);
      wr(12'h004, 8'h40);
      pin(1'b1, 20);
      rd("capt_lo", 12'h020, rv[7:0]);
      rd("capt_hi", 12'h024, rv[15:8]);
      rd("irq_flag_reg", 12'h02c, 8'h20);
      wr(12'h02c, 8'h20);
      wr(12'h004, 8'hc0);
      pin(1'b0, 20);
      pin(1'b1, 2);
      pin(1'b0, 20);
      rd("irq_flag_reg", 12'h02c, 8'h00);
      pin(1'b1, 20);
      rd("irq_flag_reg", 12'h02c, 8'h20);
      w16(12'h008, 16'h0000);
      wr(12'h004, 8'h07);
      repeat (5) begin
         xpin <= 1'b1;
         repeat (6) @(posedge hclk);
         xpin <= 1'b0;
         repeat (6) @(posedge hclk);
      end
      wr(12'h004, 8'h00);
      rd("count_lo", 12'h008, 8'h05);
      rd("count_hi", 12'h00c, 8'h00);
      summarize();
   end
endmodule : tb_timer16_capture_compare_regs
